// [hdl/sidl_map.svh]
// offsets, field positions, reset values and timing counts of the id page lock and read block
`ifndef SIDL_MAP_SVH
`define SIDL_MAP_SVH
`define SIDL_OP_MASK       8'hf7
`define SIDL_OP_READ_KIND  8'h83
`define SIDL_OP_WRITE_KIND 8'h82
`define SIDL_ADDR_TOP_BIT  7
`define SIDL_LOCK_DATA_BIT 1
`define SIDL_ERASED_BYTE   8'hff
`define SIDL_PAGE_BYTES    16
`define SIDL_GROUP_BYTES   4
`define SIDL_CODE_BITS     38
`define SIDL_CLK_PERIOD_NS 5
`define SIDL_TWC_NS        4000000
`define SIDL_TWC_CYC       (`SIDL_TWC_NS / `SIDL_CLK_PERIOD_NS)
`endif

// [hdl/sidl_pkg.sv]
// types shared by the id page lock and read block
`default_nettype none
package sidl_pkg;
    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_OP   = 7'b0000010,
        ST_ADDR = 7'b0000100,
        ST_LOCK = 7'b0001000,
        ST_ID_PAGE_READ_CMD = 7'b0010000,
        ST_LOCK_STATE_READ_CMD = 7'b0100000,
        ST_IGN  = 7'b1000000
    } sidl_state_e;
    typedef enum logic [1:0] {
        KIND_NONE  = 2'b00,
        KIND_READ  = 2'b01,
        KIND_WRITE = 2'b10
    } sidl_kind_e;
    typedef logic [7:0] sidl_byte_t;
endpackage : sidl_pkg
`default_nettype wire

// [hdl/sidl_mem_if.sv]
// carrier between the command logic and the id page store
`timescale 1ns/100ps
`default_nettype none
interface sidl_mem_if;
    logic [3:0] rd_addr;
    logic [7:0] rd_data;
    logic       wr_en;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
    logic       lock_set;
    logic       locked;
    modport ctl (output rd_addr, wr_en, wr_addr, wr_data, lock_set, input rd_data, locked);
    modport mem (input rd_addr, wr_en, wr_addr, wr_data, lock_set, output rd_data, locked);
endinterface : sidl_mem_if
`default_nettype wire

// [hdl/sidl_timer.sv]
// self-timed write cycle counter
`timescale 1ns/100ps
`default_nettype none
module sidl_timer #(
    parameter int CYCLES = 800000
) (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic start_i,
    output logic      busy_o,
    output logic      done_o
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_q, cnt_d;
    logic          busy_d, done_d;

    generate
        if (CYCLES < 1) begin : g_chk
            $error("sidl_timer: CYCLES must be at least 1");
        end
    endgenerate

    // busy lasts exactly CYCLES clocks, done pulses as busy drops
    always_comb begin
        cnt_d  = cnt_q;
        busy_d = busy_o;
        done_d = 1'b0;
        if (busy_o) begin
            if (cnt_q == '0) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - CW'(1);
            end
        end else if (start_i) begin
            busy_d = 1'b1;
            cnt_d  = CW'(CYCLES - 1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cnt_q  <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            busy_o <= busy_d;
            done_o <= done_d;
        end
    end
endmodule : sidl_timer
`default_nettype wire

// [hdl/sidl_store.sv]
// id page store, four-byte groups under single-error correction, plus the lock bit
`timescale 1ns/100ps
`default_nettype none
`include "sidl_map.svh"
module sidl_store
    import sidl_pkg::*;
#(
    parameter int PAGE_BYTES = `SIDL_PAGE_BYTES
) (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    sidl_mem_if.mem   mem
);
    localparam int GROUPS = PAGE_BYTES / `SIDL_GROUP_BYTES;
    localparam int CB     = `SIDL_CODE_BITS;

    generate
        if (PAGE_BYTES % `SIDL_GROUP_BYTES != 0 || PAGE_BYTES > 16 || PAGE_BYTES < 4) begin : g_chk
            $error("sidl_store: PAGE_BYTES must be 4, 8, 12 or 16");
        end
    endgenerate

    // hamming layout: check bits at power-of-two positions, data elsewhere
    function automatic logic [CB:1] sidl_enc(input logic [31:0] d);
        logic [CB:1] c;
        int          k;
        c = '0;
        k = 0;
        for (int i = 1; i <= CB; i++) begin
            if ((i & (i - 1)) != 0) begin
                c[i] = d[k];
                k++;
            end
        end
        for (int p = 0; p < 6; p++) begin
            for (int i = 1; i <= CB; i++) begin
                if (((i >> p) & 1) == 1 && i != (1 << p)) begin
                    c[1 << p] = c[1 << p] ^ c[i];
                end
            end
        end
        return c;
    endfunction : sidl_enc

    // syndrome names the flipped position; it is repaired before data is pulled out
    function automatic logic [31:0] sidl_dec(input logic [CB:1] cin);
        logic [CB:1] c;
        logic [5:0]  s;
        logic [31:0] d;
        int          k;
        c = cin;
        s = '0;
        d = '0;
        k = 0;
        for (int i = 1; i <= CB; i++) begin
            if (c[i]) begin
                s = s ^ 6'(i);
            end
        end
        for (int i = 1; i <= CB; i++) begin
            if (6'(i) == s) begin
                c[i] = ~c[i];
            end
        end
        for (int i = 1; i <= CB; i++) begin
            if ((i & (i - 1)) != 0) begin
                d[k] = c[i];
                k++;
            end
        end
        return d;
    endfunction : sidl_dec

    logic [GROUPS-1:0][CB:1] code_q, code_d;
    logic                    locked_q, locked_d;
    logic [31:0]             rd_grp, wr_grp;

    // corrected read, invisible to the serial side
    always_comb begin
        rd_grp      = sidl_dec(code_q[mem.rd_addr[3:2]]); // see RULE21
        mem.rd_data = rd_grp[8*mem.rd_addr[1:0] +: 8];
        mem.locked  = locked_q;
    end

    // a byte write re-encodes its whole group; the lock bit only ever sets
    always_comb begin
        code_d   = code_q;
        locked_d = locked_q | mem.lock_set; // see RULE9
        wr_grp   = sidl_dec(code_q[mem.wr_addr[3:2]]);
        if (mem.wr_en && !locked_q) begin // see RULE9
            wr_grp[8*mem.wr_addr[1:0] +: 8] = mem.wr_data;
            code_d[mem.wr_addr[3:2]]        = sidl_enc(wr_grp); // see RULE22
        end
    end

    // reset stands for the delivered state: erased page, unlocked
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            for (int g = 0; g < GROUPS; g++) begin
                code_q[g] <= sidl_enc({4{`SIDL_ERASED_BYTE}}); // see RULE19
            end
            locked_q <= 1'b0;
        end else begin
            code_q   <= code_d;
            locked_q <= locked_d;
        end
    end

    AST_LOCKED_FROZEN: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE9
        locked_q |=> $stable(code_q) && locked_q)
        else $error("id page changed while locked");
endmodule : sidl_store
`default_nettype wire

// [hdl/sidl_top.sv]
// serial command logic for id page id_page_lock_cmd page read and lock state read
//
// How it works
// RULE1 - lock only proceeds when the write latch bit is set.
// RULE2 - host sends lock opcode, address with top bit one, then one data byte.
// RULE3 - lock data byte must have bit 1 set; other bits ignored.
// RULE4 - chip select must rise after eighth data edge, before the next rising edge.
// RULE5 - valid lock at byte boundary starts the self-timed write cycle.
// RULE6 - lock refused when both block guard bits are one.
// RULE7 - lock refused while a write cycle runs.
// RULE8 - lock refused when page is already locked.
// RULE9 - once locked, page stays read-only forever.
// RULE10 - page read: top address bit zero, low four bits pick the byte.
// RULE11 - page read keeps incrementing address and streaming bytes.
// RULE12 - host must not read past sixteen bytes; no wraparound.
// RULE13 - rising chip select ends a read anywhere, even mid-byte.
// RULE14 - page read ignored during a write cycle.
// RULE15 - lock state read: top address bit one, others ignored.
// RULE16 - lock state byte has lsb one when locked, zero otherwise.
// RULE17 - lock state byte repeats while chip select stays low.
// RULE18 - lock state read ignored during a write cycle.
// RULE19 - delivered storage reads all ones.
// RULE20 - instructions ignored during reset; afterwards idle and deselected.
// RULE21 - each four-byte group corrects a single bit error on read.
// RULE22 - a byte write rewrites its whole four-byte group.
// RULE23 - read opcode ignores bit 3; top address bit picks page or lock state.
// RULE24 - write opcode ignores bit 3; top address bit picks page write or lock.
// RULE25 - during a write cycle every opcode here is ignored.
// RULE26 - lock completion clears the write latch bit.
`timescale 1ns/100ps
`default_nettype none
`include "sidl_map.svh"
module sidl_top
    import sidl_pkg::*;
#(
    parameter int WC_CYCLES  = `SIDL_TWC_CYC,
    parameter int PAGE_BYTES = `SIDL_PAGE_BYTES
) (
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       cs_n_i,
    input  wire logic       sck_i,
    input  wire logic       si_i,
    input  wire logic       write_latch_bit_i,
    input  wire logic       block_guard_hi_i,
    input  wire logic       block_guard_lo_i,
    input  wire logic       ext_busy_i,
    input  wire logic       id_wr_en_i,
    input  wire logic [3:0] id_wr_addr_i,
    input  wire logic [7:0] id_wr_data_i,
    output logic            so_o,
    output logic            so_oe_n_o,
    output logic            write_busy_o,
    output logic            id_locked_o,
    output logic            write_latch_clr_o
);
    sidl_mem_if mem_if ();

    // past-end detection assumes a full page, and the cycle-start check needs at least 8 busy clocks
    generate
        if (WC_CYCLES < 8 || PAGE_BYTES != 16) begin : g_chk
            $error("sidl_top: WC_CYCLES must be at least 8 and PAGE_BYTES must be 16");
        end
    endgenerate

    logic [2:0]  cs_q, sck_q;
    logic [1:0]  si_q;
    logic        cs_rise, sck_rise, sck_fall, si_s, busy, byte_done;
    sidl_byte_t  rx_byte;
    logic        tmr_done, lock_go, lock_done;

    sidl_state_e state_q, state_d;
    sidl_kind_e  kind_q, kind_d;
    logic [2:0]  cnt_q, cnt_d;
    sidl_byte_t  sh_q, sh_d, out_q, out_d;
    logic [4:0]  addr_q, addr_d;
    logic        armed_q, armed_d, lockbit_q, lockbit_d;
    logic        so_d, oe_n_d, pend_q, pend_d, clr_d;

    // pins cross into clk_i through two flops; third stage of sck/cs is only edge history
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cs_q  <= 3'h7;
            sck_q <= 3'h0;
            si_q  <= 2'h0;
        end else begin
            cs_q  <= {cs_q[1:0], cs_n_i};
            sck_q <= {sck_q[1:0], sck_i};
            si_q  <= {si_q[0], si_i};
        end
    end

    // si and sck share the same delay, so the sampled bit lines up with the edge
    assign cs_rise   = cs_q[1] & ~cs_q[2];
    assign sck_rise  = sck_q[1] & ~sck_q[2];
    assign sck_fall  = ~sck_q[1] & sck_q[2];
    assign si_s      = si_q[1];
    assign rx_byte   = {sh_q[6:0], si_s};
    assign byte_done = sck_rise && (cnt_q == 3'h7);
    assign busy      = write_busy_o | ext_busy_i;
    assign lock_done = tmr_done & pend_q;

    // store hookup: the address byte itself selects the first read byte
    assign mem_if.rd_addr  = (state_q == ST_ADDR) ? rx_byte[3:0] : addr_q[3:0]; // see RULE10
    assign mem_if.wr_en    = id_wr_en_i;
    assign mem_if.wr_addr  = id_wr_addr_i;
    assign mem_if.wr_data  = id_wr_data_i;
    assign mem_if.lock_set = lock_done; // see RULE9

    // lock is judged at the chip select rise, only from the armed boundary slot
    always_comb begin
        lock_go = 1'b0;
        if (cs_rise && state_q == ST_LOCK && armed_q) begin // see RULE4
            lock_go = write_latch_bit_i // see RULE1
                & ~(block_guard_hi_i & block_guard_lo_i) // see RULE6
                & ~busy // see RULE7
                & ~mem_if.locked // see RULE8
                & lockbit_q; // see RULE3
        end
    end

    // frame decoder: opcode, address, then lock data or read stream
    always_comb begin
        state_d   = state_q;
        kind_d    = kind_q;
        cnt_d     = cnt_q;
        sh_d      = sh_q;
        out_d     = out_q;
        addr_d    = addr_q;
        armed_d   = armed_q;
        lockbit_d = lockbit_q;
        so_d      = so_q_hold();
        oe_n_d    = so_oe_n_o;
        pend_d    = (pend_q & ~tmr_done) | lock_go; // see RULE5
        clr_d     = lock_done; // see RULE26
        if (cs_q[1]) begin
            state_d = ST_IDLE; // see RULE13
            cnt_d   = 3'h0;
            armed_d = 1'b0;
            oe_n_d  = 1'b1;
        end else begin
            if (state_q == ST_IDLE) begin
                state_d = ST_OP;
            end
            if (sck_rise) begin
                sh_d  = rx_byte;
                cnt_d = cnt_q + 3'h1;
                if (state_q == ST_LOCK && armed_q) begin
                    state_d = ST_IGN; // see RULE4
                    armed_d = 1'b0;
                end
            end
            if (byte_done) begin
                case (state_q)
                    ST_IDLE, ST_OP: begin
                        if (busy) begin
                            state_d = ST_IGN; // see RULE14, RULE18, RULE25
                        end else if ((rx_byte & `SIDL_OP_MASK) == `SIDL_OP_READ_KIND) begin // see RULE23
                            kind_d  = KIND_READ;
                            state_d = ST_ADDR;
                        end else if ((rx_byte & `SIDL_OP_MASK) == `SIDL_OP_WRITE_KIND) begin // see RULE24
                            kind_d  = KIND_WRITE;
                            state_d = ST_ADDR;
                        end else begin
                            state_d = ST_IGN;
                        end
                    end
                    ST_ADDR: begin
                        if (kind_q == KIND_READ) begin
                            oe_n_d = 1'b0;
                            if (rx_byte[`SIDL_ADDR_TOP_BIT]) begin
                                state_d = ST_LOCK_STATE_READ_CMD;
                                out_d   = {7'h00, mem_if.locked}; // see RULE16
                            end else begin
                                state_d = ST_ID_PAGE_READ_CMD;
                                out_d   = mem_if.rd_data; // see RULE10
                                addr_d  = {1'b0, rx_byte[3:0]} + 5'h01;
                            end
                        end else if (rx_byte[`SIDL_ADDR_TOP_BIT]) begin
                            state_d = ST_LOCK;
                        end else begin
                            state_d = ST_IGN; // page write lives elsewhere
                        end
                    end
                    ST_LOCK: begin
                        if (!armed_q) begin
                            lockbit_d = rx_byte[`SIDL_LOCK_DATA_BIT];
                            armed_d   = 1'b1;
                        end
                    end
                    ST_ID_PAGE_READ_CMD: begin
                        // past the page end the stream reads erased, no wraparound
                        out_d = addr_q[4] ? `SIDL_ERASED_BYTE : mem_if.rd_data; // see RULE11
                        if (!addr_q[4]) begin
                            addr_d = addr_q + 5'h01;
                        end
                    end
                    ST_LOCK_STATE_READ_CMD: begin
                        out_d = {7'h00, mem_if.locked}; // see RULE17
                    end
                    default: begin
                    end
                endcase
            end
            if (sck_fall && (state_q == ST_ID_PAGE_READ_CMD || state_q == ST_LOCK_STATE_READ_CMD)) begin
                so_d  = out_q[7];
                out_d = {out_q[6:0], 1'b1};
            end
        end
    end

    function automatic logic so_q_hold();
        return so_o;
    endfunction : so_q_hold

    // every frame register starts deselected and idle
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_q           <= ST_IDLE; // see RULE20
            kind_q            <= KIND_NONE;
            cnt_q             <= 3'h0;
            sh_q              <= 8'h00;
            out_q             <= 8'h00;
            addr_q            <= 5'h00;
            armed_q           <= 1'b0;
            lockbit_q         <= 1'b0;
            so_o              <= 1'b0;
            so_oe_n_o         <= 1'b1;
            pend_q            <= 1'b0;
            write_latch_clr_o <= 1'b0;
        end else begin
            state_q           <= state_d;
            kind_q            <= kind_d;
            cnt_q             <= cnt_d;
            sh_q              <= sh_d;
            out_q             <= out_d;
            addr_q            <= addr_d;
            armed_q           <= armed_d;
            lockbit_q         <= lockbit_d;
            so_o              <= so_d;
            so_oe_n_o         <= oe_n_d;
            pend_q            <= pend_d;
            write_latch_clr_o <= clr_d;
        end
    end

    assign id_locked_o = mem_if.locked;

    sidl_timer #(
        .CYCLES (WC_CYCLES)
    ) u_timer (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .start_i   (lock_go),
        .busy_o    (write_busy_o),
        .done_o    (tmr_done)
    );

    sidl_store #(
        .PAGE_BYTES (PAGE_BYTES)
    ) u_store (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .mem       (mem_if.mem)
    );

    // checks
    AST_LOCK_WEL: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE1
        lock_go |-> write_latch_bit_i && lockbit_q)
        else $error("lock started without latch or data bit");
    AST_LOCK_GUARD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE6
        (block_guard_hi_i && block_guard_lo_i) |-> !lock_go)
        else $error("lock started with both guard bits set");
    AST_LOCK_BUSY: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE7
        lock_go |-> !$past(write_busy_o) && !write_busy_o && !ext_busy_i)
        else $error("lock started during a write cycle");
    AST_LOCK_ONCE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE8
        id_locked_o |-> !lock_go)
        else $error("lock started on a locked page");
    AST_CYCLE_START: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE5
        lock_go |=> write_busy_o [*8])
        else $error("write cycle did not start on lock");
    AST_LOCK_DONE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE26
        $fell(write_busy_o) && pend_q |=> write_latch_clr_o && id_locked_o)
        else $error("lock completion missed latch clear or lock bit");
    AST_NO_UNLOCK: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE9
        !$fell(id_locked_o))
        else $error("lock bit dropped");
    AST_BUSY_IGNORE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE25
        (state_q == ST_OP) && byte_done && busy && !cs_q[1] |=> state_q == ST_IGN)
        else $error("opcode taken during write cycle");
    AST_CS_ENDS: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE13
        cs_rise |=> (state_q == ST_IDLE) && so_oe_n_o)
        else $error("frame survived chip select rise");
    AST_LS_BYTE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE16
        (state_q == ST_LOCK_STATE_READ_CMD) && byte_done && !cs_q[1] |=> out_q == {7'h00, id_locked_o})
        else $error("lock state byte wrong");
    AST_LATE_EDGE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see RULE4
        (state_q == ST_LOCK) && armed_q && sck_rise && !cs_q[1] |=> !armed_q ##0 !lock_go)
        else $error("lock still armed after extra clock edge");

    COV_LOCK: cover property (@(posedge clk_i) disable iff (!reset_n_i) lock_done);
    COV_ID_PAGE_READ_CMD: cover property (@(posedge clk_i) disable iff (!reset_n_i) (state_q == ST_ID_PAGE_READ_CMD) && byte_done);
    COV_LOCK_STATE_READ_CMD: cover property (@(posedge clk_i) disable iff (!reset_n_i) (state_q == ST_LOCK_STATE_READ_CMD) && byte_done);
    COV_LOCK_REFUSED: cover property (@(posedge clk_i) disable iff (!reset_n_i)
        cs_rise && (state_q == ST_LOCK) && armed_q && !lock_go);
    COV_BUSY_IGNORE: cover property (@(posedge clk_i) disable iff (!reset_n_i)
        (state_q == ST_OP) && byte_done && busy);
endmodule : sidl_top
`default_nettype wire

// [tb/sidl_host.sv]
// spi host model: drives chip select, serial clock and serial input
`timescale 1ns/100ps
`default_nettype none
module sidl_host (
    input  wire logic so_i,
    input  wire logic so_oe_n_i,
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o
);
    logic [7:0] rx;
    event       got;
    // idle: deselected, clock parked low between frames
    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
    end
    // one mode 0 bit; so counts as unknown while the device is not driving it
    task automatic bit_x(input logic b, output logic r);
        si_o = b;
        #32 sck_o = 1'b1;
        r = so_oe_n_i ? 1'bx : so_i;
        #32 sck_o = 1'b0;
    endtask : bit_x
    // opcode, address, nd data bits, nr read bits; the odd offset keeps link edges off clock edges
    task automatic frame(input logic [7:0] op, input logic [7:0] ad, input logic [7:0] dat,
                         input int nd, input int nr);
        logic r;
        #1.3 cs_n_o = 1'b0;
        #32;
        for (int i = 15; i >= 0; i--) bit_x(i > 7 ? op[i-8] : ad[i], r);
        for (int i = 0; i < nd; i++) bit_x(dat[7-(i%8)], r);
        for (int i = 0; i < nr; i++) begin
            bit_x(~si_o, r); // si toggles so a stale level is never mistaken for data
            rx = {rx[6:0], r};
            if (i % 8 == 7) ->got;
        end
        #16 cs_n_o = 1'b1;
        si_o = ~si_o;
        #64;
    endtask : frame
endmodule : sidl_host
`default_nettype wire

// [tb/tb_sidl_top.sv]
// self-checking bench of the id page lock and read block
`timescale 1ns/100ps
`default_nettype none
module tb_sidl_top;
    import sidl_pkg::*;
    localparam int WC = 800; // long enough that two read frames start inside the write cycle
    logic       clk = 1'b0, rst_n = 1'b0, latch = 1'b0, g_hi = 1'b0, g_lo = 1'b0, ext = 1'b0;
    logic       wr_en = 1'b0, cs_n, sck, si, so, oe_n, busy, locked, clr;
    logic [3:0] wr_a = 4'h0;
    sidl_byte_t wr_d = 8'h00, d0, d1;
    int         fail_count = 0, total_checks = 0, busy_n = 0, clr_n = 0, oe_cnt = 0, o0;
    sidl_byte_t exp_q[$];
    logic [3:0] cfg[6] = '{4'b0000, 4'b1110, 4'b1001, 4'b1000, 4'b1000, 4'b1000};
    sidl_byte_t ldat[6] = '{8'h02, 8'h02, 8'h02, 8'hfd, 8'h02, 8'h02};
    int         nd[6] = '{8, 8, 8, 8, 9, 8};

    always #2.5 clk = ~clk;

    sidl_top #(.WC_CYCLES(WC)) dut (
        .clk_i(clk), .reset_n_i(rst_n), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
        .write_latch_bit_i(latch), .block_guard_hi_i(g_hi), .block_guard_lo_i(g_lo),
        .ext_busy_i(ext), .id_wr_en_i(wr_en), .id_wr_addr_i(wr_a), .id_wr_data_i(wr_d),
        .so_o(so), .so_oe_n_o(oe_n), .write_busy_o(busy), .id_locked_o(locked),
        .write_latch_clr_o(clr)
    );
    sidl_host host (.so_i(so), .so_oe_n_i(oe_n), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));

    // counts busy cycles, latch clear pulses and cycles with so driven
    always @(posedge clk) begin
        busy_n <= busy_n + int'(busy === 1'b1);
        clr_n <= clr_n + int'(clr === 1'b1);
        oe_cnt <= oe_cnt + int'(oe_n === 1'b0);
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    // every byte the host collects is matched against the oldest note
    always @(host.got) begin
        if (exp_q.size() == 0) exp_q.push_back(~host.rx); // an unexpected byte never matches unless all its bits are unknown
        check(host.rx, exp_q.pop_front());
    end

    // hang guard, well beyond the roughly 12000 cycles the tests take
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        end_of_test();
    end

    // main sequence
    initial begin
        void'($urandom(32'hb519e58e));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check({6'h0, busy, locked}, 8'h00);
        exp_q = '{8'hff, 8'hff};
        host.frame(8'h83, 8'h00, 8'h00, 0, 16);
        $display("test delivered read done");
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        @(posedge clk);
        {wr_en, wr_a, wr_d} <= {1'b1, 4'he, d0};
        @(posedge clk);
        {wr_a, wr_d} <= {4'hf, d1};
        @(posedge clk);
        wr_en <= 1'b0;
        exp_q = '{d0, d1, 8'hff};
        host.frame(8'h8b, 8'h7e, 8'h00, 0, 24);
        exp_q = '{8'h00, 8'h00};
        host.frame(8'h83, 8'h80, 8'h00, 0, 16);
        $display("test stream read done");
        // refused lock attempts: latch off, guards both set, busy, bad data bit, extra clock, page write address
        for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            {latch, g_hi, g_lo, ext} <= cfg[k];
            host.frame(8'h8a, {1'(k != 5), 7'h00}, ldat[k], nd[k], 0);
            repeat (WC + 8) @(posedge clk);
            check(8'(busy_n), 8'h00);
            check({7'h0, locked}, 8'h00);
        end
        $display("test refused lock done");
        @(posedge clk);
        {latch, g_hi, g_lo, ext} <= {1'b1, 1'($urandom), 2'b00};
        host.frame(8'h82, {1'b1, 7'($urandom)}, 8'($urandom) | 8'h02, 8, 0);
        o0 = oe_cnt;
        exp_q = '{8'hxx, 8'hxx};
        host.frame(8'h83, 8'h00, 8'h00, 0, 8);
        host.frame(8'h8b, 8'h80, 8'h00, 0, 8);
        check(8'(oe_cnt - o0), 8'h00);
        repeat (WC) @(posedge clk);
        check(busy_n[15:8], 8'(WC >> 8));
        check(busy_n[7:0], 8'(WC));
        check({6'h0, 1'(clr_n), locked}, 8'h03);
        $display("test lock done");
        @(posedge clk);
        {wr_en, wr_a, wr_d} <= {1'b1, 4'he, ~d0};
        @(posedge clk);
        wr_en <= 1'b0;
        host.frame(8'h82, 8'h80, 8'h02, 8, 0);
        repeat (WC + 8) @(posedge clk);
        check(8'(busy_n - WC), 8'h00);
        exp_q = '{8'h01, 8'h01, d0};
        host.frame(8'h83, 8'h80, 8'h00, 0, 16);
        host.frame(8'h83, 8'h0e, 8'h00, 0, 11);
        repeat (8) @(posedge clk);
        check({7'h0, oe_n}, 8'h01);
        $display("test after lock done");
        end_of_test();
    end
endmodule : tb_sidl_top
`default_nettype wire
